//--- inc/psl_pkg.sv
package psl_pkg;
   // Link timing at a 4 ns clock period.
   localparam int CLK_PERIOD_PS        = 4000;
   localparam int SYMBOL_NS            = 1250;
   localparam int SYMBOL_TOL_NS        = 300;
   localparam int ZERO_HIGH_MIN_NS     = 300;
   localparam int ZERO_HIGH_MAX_NS     = 450;
   localparam int ONE_HIGH_MIN_NS      = 750;
   localparam int ONE_HIGH_MAX_NS      = 1000;
   localparam int BIT_LOW_MIN_NS       = 300;
   localparam int BIT_LOW_MAX_US       = 100;
   localparam int FRAME_END_LOW_US     = 300;
   localparam int SAMPLE_NS            = (ZERO_HIGH_MAX_NS + ONE_HIGH_MIN_NS) / 2;
   // Sender high times, chosen inside the legal windows.
   localparam int ZERO_HIGH_NS         = 400;
   localparam int ONE_HIGH_NS          = 850;
   localparam int ZERO_HIGH_CYC        = (ZERO_HIGH_NS * 1000) / CLK_PERIOD_PS;
   localparam int ONE_HIGH_CYC         = (ONE_HIGH_NS * 1000) / CLK_PERIOD_PS;
   localparam int SYMBOL_CYC           = (SYMBOL_NS * 1000) / CLK_PERIOD_PS;
   localparam int SAMPLE_CYC           = (SAMPLE_NS * 1000) / CLK_PERIOD_PS;
   localparam int FRAME_END_LOW_CYC    =
      (FRAME_END_LOW_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Silence on the primary input that triggers the switch to the backup input.
   localparam int BACKUP_IDLE_CYC      = FRAME_END_LOW_CYC;
   localparam int WORD_BITS            = 24;
   localparam int CNT_W                = 20;
   localparam int BIT_CNT_W            = 5;
endpackage : psl_pkg

//--- inc/psl_link_if.sv
`timescale 1ns/1ps
interface psl_link_if;
   logic serial_data;
   logic backup_serial_in;
   modport sender
   (
      output serial_data,
      output backup_serial_in
   );
   modport pixel
   (
      input  serial_data,
      input  backup_serial_in
   );
endinterface : psl_link_if

//--- logic/psl_pixel.sv
`timescale 1ns/1ps
module psl_pixel
   import psl_pkg::*;
#(
   parameter int FRAME_END_CYC = FRAME_END_LOW_CYC,
   parameter int BACKUP_CYC    = BACKUP_IDLE_CYC
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Link input
   psl_link_if.pixel        link_in,
   // Forwarded output towards the next pixel
   output logic             serial_out,
   // Colour latch and backup status
   output logic [7:0]       green,
   output logic [7:0]       red,
   output logic [7:0]       blue,
   output logic             word_valid,
   output logic             on_backup
);
   logic [2:0]           prim_sync_r;
   logic [2:0]           back_sync_r;
   logic                 prim_r;
   logic                 back_r;
   logic                 on_backup_r;
   logic                 in_prev_r;
   logic [CNT_W-1:0]     rise_cnt_r;
   logic                 armed_r;
   logic [CNT_W-1:0]     low_cnt_r;
   logic [CNT_W-1:0]     prim_idle_r;
   logic [BIT_CNT_W-1:0] bit_cnt_r;
   logic [WORD_BITS-1:0] shift_r;
   logic                 latched_r;
   logic                 fwd_r;
   logic [CNT_W-1:0]     fwd_cnt_r;
   logic                 fwd_one_r;
   logic                 serial_out_r;

   // Three-stage synchronisers; a change counts once stages two and three agree.
   wire   prim_agree = (prim_sync_r[1] == prim_sync_r[2]);
   wire   back_agree = (back_sync_r[1] == back_sync_r[2]);
   wire   line_in    = on_backup_r ? back_r : prim_r;
   wire   rise       = line_in & ~in_prev_r;
   wire   sample_now = armed_r & (rise_cnt_r == CNT_W'(SAMPLE_CYC - 1));
   wire   frame_end  = ~line_in & (low_cnt_r >= CNT_W'(FRAME_END_CYC));
   wire   take_bit   = sample_now & ~latched_r;
   wire   pass_bit   = sample_now & latched_r;
   wire   last_bit   = take_bit & (bit_cnt_r == BIT_CNT_W'(WORD_BITS - 1));
   wire   fwd_high   = fwd_one_r ? (fwd_cnt_r < CNT_W'(ONE_HIGH_CYC))
                                 : (fwd_cnt_r < CNT_W'(ZERO_HIGH_CYC));

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         prim_sync_r <= 3'h0;
         back_sync_r <= 3'h0;
         prim_r      <= 1'b0;
         back_r      <= 1'b0;
      end
      else
      begin
         prim_sync_r <= {prim_sync_r[1:0], link_in.serial_data};
         back_sync_r <= {back_sync_r[1:0], link_in.backup_serial_in};
         if (prim_agree)
            prim_r <= prim_sync_r[2];
         if (back_agree)
            back_r <= back_sync_r[2];
      end
   end

   // Backup failover holds until the next reset, standing in for power cycling.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         prim_idle_r <= '0;
         on_backup_r <= 1'b0;
      end
      else
      begin
         if (prim_r)
            prim_idle_r <= '0;
         else if (prim_idle_r != CNT_W'(BACKUP_CYC))
            prim_idle_r <= prim_idle_r + CNT_W'(1);
         if (prim_idle_r == CNT_W'(BACKUP_CYC) && back_r && !prim_r)
            on_backup_r <= 1'b1;
      end
   end

   // Time since the last rising edge, and low duration on the selected input.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         in_prev_r  <= 1'b0;
         rise_cnt_r <= '0;
         armed_r    <= 1'b0;
         low_cnt_r  <= '0;
      end
      else
      begin
         in_prev_r <= line_in;
         if (rise)
         begin
            armed_r    <= 1'b1;
            rise_cnt_r <= '0;
         end
         else if (sample_now)
            armed_r <= 1'b0;
         else if (armed_r)
            rise_cnt_r <= rise_cnt_r + CNT_W'(1);
         if (line_in)
            low_cnt_r <= '0;
         else if (!frame_end)
            low_cnt_r <= low_cnt_r + CNT_W'(1);
      end
   end

   // Capture the first word of the frame, green first and MSB first.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         bit_cnt_r <= '0;
         shift_r   <= '0;
         latched_r <= 1'b0;
         green     <= 8'h00;
         red       <= 8'h00;
         blue      <= 8'h00;
         word_valid <= 1'b0;
      end
      else
      begin
         word_valid <= 1'b0;
         if (frame_end)
         begin
            bit_cnt_r <= '0;
            latched_r <= 1'b0;
         end
         else if (take_bit)
         begin
            shift_r   <= {shift_r[WORD_BITS-2:0], line_in};
            bit_cnt_r <= bit_cnt_r + BIT_CNT_W'(1);
            if (last_bit)
            begin
               latched_r  <= 1'b1;
               green      <= shift_r[22:15];
               red        <= shift_r[14:7];
               blue       <= {shift_r[6:0], line_in};
               word_valid <= 1'b1;
            end
         end
      end
   end

   // Reshaped output: each passed bit is re-timed to a clean symbol.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         fwd_r        <= 1'b0;
         fwd_cnt_r    <= '0;
         fwd_one_r    <= 1'b0;
         serial_out_r <= 1'b0;
      end
      else
      begin
         // A passed bit is regenerated from its sampling point onwards.
         if (pass_bit)
         begin
            fwd_r     <= 1'b1;
            fwd_cnt_r <= '0;
            fwd_one_r <= line_in;
         end
         else if (fwd_r && !fwd_high)
            fwd_r <= 1'b0;
         else if (fwd_r)
            fwd_cnt_r <= fwd_cnt_r + CNT_W'(1);
         serial_out_r <= fwd_r & fwd_high;
      end
   end

   assign serial_out = serial_out_r;
   assign on_backup  = on_backup_r;
endmodule : psl_pixel

//--- logic/psl_sender.sv
`timescale 1ns/1ps
module psl_sender
   import psl_pkg::*;
#(
   parameter int FRAME_END_CYC = FRAME_END_LOW_CYC
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Word request
   input  wire logic [23:0] word,
   input  wire logic        word_valid,
   input  wire logic        frame_done,
   output logic             word_ready,
   // Link output
   psl_link_if.sender       link_out
);
   typedef enum logic [1:0] {ST_IDLE, ST_BITS, ST_GAP} psl_send_e;
   psl_send_e            state_r;
   logic [WORD_BITS-1:0] shift_r;
   logic [BIT_CNT_W-1:0] bit_cnt_r;
   logic [CNT_W-1:0]     cnt_r;
   logic                 line_r;
   logic                 ready_r;

   wire   high_len = shift_r[WORD_BITS-1] ? (cnt_r < CNT_W'(ONE_HIGH_CYC))
                                          : (cnt_r < CNT_W'(ZERO_HIGH_CYC));
   wire   sym_end  = (cnt_r == CNT_W'(SYMBOL_CYC - 1));
   wire   gap_end  = (cnt_r == CNT_W'(FRAME_END_CYC));

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_r   <= ST_IDLE;
         shift_r   <= '0;
         bit_cnt_r <= '0;
         cnt_r     <= '0;
         line_r    <= 1'b0;
         ready_r   <= 1'b0;
      end
      else
      begin
         ready_r <= 1'b0;
         case (state_r)
            ST_IDLE:
            begin
               line_r <= 1'b0;
               cnt_r  <= '0;
               if (word_valid)
               begin
                  shift_r   <= word;
                  bit_cnt_r <= '0;
                  state_r   <= ST_BITS;
                  ready_r   <= 1'b1;
               end
               else if (frame_done)
                  state_r <= ST_GAP;
            end
            ST_BITS:
            begin
               line_r <= high_len;
               cnt_r  <= cnt_r + CNT_W'(1);
               if (sym_end)
               begin
                  cnt_r     <= '0;
                  shift_r   <= {shift_r[WORD_BITS-2:0], 1'b0};
                  bit_cnt_r <= bit_cnt_r + BIT_CNT_W'(1);
                  if (bit_cnt_r == BIT_CNT_W'(WORD_BITS - 1))
                     state_r <= ST_IDLE;
               end
            end
            ST_GAP:
            begin
               line_r <= 1'b0;
               cnt_r  <= cnt_r + CNT_W'(1);
               if (gap_end)
                  state_r <= ST_IDLE;
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   assign word_ready                = ready_r;
   assign link_out.serial_data      = line_r;
   assign link_out.backup_serial_in = line_r;
endmodule : psl_sender

//--- tb/psl_link_assertions.sv
`timescale 1ns/1ps
module psl_link_assertions
   import psl_pkg::*;
#(
   parameter int FRAME_END_CYC = FRAME_END_LOW_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Link wires
   input wire logic serial_data,
   input wire logic backup_serial_in
);
   logic [CNT_W-1:0] hi_r;
   logic [CNT_W-1:0] lo_r;
   logic [CNT_W-1:0] hl_r;
   logic             seen_r;
   // Run lengths of the line; the low count saturates across long gaps.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         hi_r   <= '0;
         lo_r   <= '0;
         hl_r   <= '0;
         seen_r <= 1'h0;
      end
      else
      begin
         hi_r <= serial_data ? hi_r + 1'h1 : '0;
         lo_r <= (serial_data || &lo_r) ? (serial_data ? '0 : lo_r) : lo_r + 1'h1;
         if (!serial_data && hi_r != '0)
         begin
            hl_r   <= hi_r;
            seen_r <= 1'h1;
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_high_len;
      $fell(serial_data) |-> hi_r == ZERO_HIGH_CYC || hi_r == ONE_HIGH_CYC;
   endproperty
   a_high_len: assert property (p_high_len) else $error("bad high time");
   property p_high_max;
      serial_data |-> hi_r < 250;
   endproperty
   a_high_max: assert property (p_high_max) else $error("high too long");
   property p_fall_in;
      $rose(serial_data) |-> ##[75:250] !serial_data;
   endproperty
   a_fall_in: assert property (p_fall_in) else $error("no fall in time");
   property p_low_run;
      $fell(serial_data) |-> !serial_data [*8];
   endproperty
   a_low_run: assert property (p_low_run) else $error("low too short");
   property p_low_len;
      $rose(serial_data) && seen_r |-> lo_r >= 75 && (lo_r <= 25000 || lo_r >= FRAME_END_CYC);
   endproperty
   a_low_len: assert property (p_low_len) else $error("bad low time");
   property p_symbol;
      $rose(serial_data) && seen_r && lo_r < FRAME_END_CYC |-> hl_r + lo_r inside {[237:387]};
   endproperty
   a_symbol: assert property (p_symbol) else $error("bad symbol length");
   property p_mirror;
      backup_serial_in == serial_data;
   endproperty
   a_mirror: assert property (p_mirror) else $error("backup differs");
   property p_reset_idle;
      $rose(rst_n) |-> !serial_data;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("line high after reset");
   c_zero: cover property ($fell(serial_data) && hi_r == ZERO_HIGH_CYC);
   c_one: cover property ($fell(serial_data) && hi_r == ONE_HIGH_CYC);
   c_gap: cover property ($rose(serial_data) && lo_r >= FRAME_END_CYC);
endmodule : psl_link_assertions

//--- tb/test_pixel_serial_link.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin check_count++; if ((got) !== (exp)) begin fails++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module test_pixel_serial_link
   import psl_pkg::*;
();
   localparam int FE = 500;
   localparam int WCYC = WORD_BITS * SYMBOL_CYC;
   typedef struct packed {logic [23:0] a; logic [23:0] b;} psl_row_s;
   psl_row_s    rows [2] = '{'{24'hFF0000, 24'h00FF01}, '{24'h000001, 24'h800000}};
   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic [23:0] word = '0;
   logic        wvalid = 1'h0;
   logic        fdone = 1'h0;
   logic        kill = 1'h0;
   logic        wready, so0, v0, v1, ob0, ob1;
   logic [7:0]  g0, r0, b0, g1, r1, b1;
   int          fails = 0;
   int          check_count = 0;
   psl_link_if lnk ();
   psl_link_if lnk2 ();
   // The second pixel's primary wire can be cut to force the backup path.
   assign lnk2.serial_data = so0 & ~kill;
   assign lnk2.backup_serial_in = so0;
   psl_link_assertions #(.FRAME_END_CYC(FE)) psl_link_assertions_inst (.clk(clk),
      .rst_n(rst_n), .serial_data(lnk.serial_data), .backup_serial_in(lnk.backup_serial_in));
   psl_sender #(.FRAME_END_CYC(FE)) psl_sender_inst (.clk(clk), .rst_n(rst_n), .word(word),
      .word_valid(wvalid), .frame_done(fdone), .word_ready(wready), .link_out(lnk.sender));
   psl_pixel #(.FRAME_END_CYC(FE), .BACKUP_CYC(FE)) psl_pixel_inst (.clk(clk), .rst_n(rst_n),
      .link_in(lnk.pixel), .serial_out(so0), .green(g0), .red(r0), .blue(b0),
      .word_valid(v0), .on_backup(ob0));
   psl_pixel #(.FRAME_END_CYC(FE), .BACKUP_CYC(FE)) psl_pixel_inst_b (.clk(clk),
      .rst_n(rst_n), .link_in(lnk2.pixel), .serial_out(), .green(g1), .red(r1), .blue(b1),
      .word_valid(v1), .on_backup(ob1));
   always #2 clk = ~clk;
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic complete_run();
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   task automatic send_word(input logic [23:0] w);
      int n;
      n = 0;
      tick(1);
      word = w;
      wvalid = 1'h1;
      do
      begin
         tick(1);
         n++;
      end while (wready !== 1'h1 && n < 20000);
      wvalid = 1'h0;
      if (n >= 20000)
      begin
         fails++;
         complete_run();
      end
   endtask : send_word
   task automatic send_frame(input logic [23:0] a, input logic [23:0] b, input bit two);
      send_word(a);
      if (two)
         send_word(b);
      tick(1);
      fdone = 1'h1;
      tick(WCYC + 50);
      fdone = 1'h0;
      tick(FE + 50);
   endtask : send_frame
   initial
   begin
      tick(16);
      rst_n = 1'h1;
      foreach (rows[i])
      begin
         send_frame(rows[i].a, rows[i].b, 1);
         `CHK({g0, r0, b0}, rows[i].a)
         `CHK({g1, r1, b1}, rows[i].b)
      end
      $display("row test done");
      send_frame(24'h0F0F0F, 24'h0, 0);
      `CHK({g0, r0, b0}, 24'h0F0F0F)
      `CHK({g1, r1, b1}, rows[1].b)
      $display("single word test done");
      kill = 1'h1;
      send_frame(24'h111111, 24'h222222, 1);
      `CHK(ob1, 1'h1)
      kill = 1'h0;
      send_frame(24'h333333, 24'h444444, 1);
      `CHK(ob1, 1'h1)
      `CHK({g1, r1, b1}, 24'h444444)
      `CHK(ob0, 1'h0)
      $display("backup test done");
      send_word(24'hFFFFFF);
      tick(100);
      rst_n = 1'h0;
      tick(2);
      `CHK({ob1, so0, g0, r0, b0}, 26'h0)
      rst_n = 1'h1;
      send_frame(24'hA1B2C3, 24'h0000FF, 1);
      `CHK({g0, r0, b0, g1, r1, b1}, 48'hA1B2C30000FF)
      $display("reset test done");
      complete_run();
   end
endmodule : test_pixel_serial_link
